// ===== rtl/sdj_core.sv
// Purpose: Speed command generation with direct, jog and PI modes.
// Assumes: Pins RUN, STOP and JOG are asynchronous; POS_ERR is on CLOCK.
// Notes:   SPEED_CMD is two's complement, full scale is +/-4095 counts.
// Operation
// - Direct mode drives command open loop, unramped.
// - Direct value uses twelve bits of magnitude.
// - 4095 full, 2048 half, 0 zero forward.
// - Negative value drives reverse by its magnitude.
// - Mode selector value 2 selects direct mode.
// - Direct mode disables follower profile and integrator.
// - Direct value resets to zero.
// - Run and stop gate the direct value.
// - Jog ramps speed at set rate to setpoint.
// - Jog only from fast stop, returns there.
// - Ramp setting is tenths of a second from zero to setpoint.
// - Jog setpoint in rpm, default 50.
// - Gain defaults 3000, integral defaults 1.
// - Larger gain gives proportionally stronger correction.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module sdj_core #(
  parameter int          ERR_W    = 16,
  parameter int          KP_SHIFT = 12,
  parameter int          KI_SHIFT = 16,
  parameter int          FULL_RPM = 3000,
  parameter int unsigned UNIT_CYC = sdj_pkg::RAMP_UNIT_CYC
) (
  input  wire logic                      CLOCK,
  input  wire logic                      SRST,
  input  wire sdj_pkg::sdj_apb_req_t     APB_REQ,
  output sdj_pkg::sdj_apb_rsp_t          APB_RSP,
  input  wire logic                      RUN_PIN,
  input  wire logic                      STOP_PIN,
  input  wire logic                      JOG_PIN,
  input  wire logic signed [ERR_W-1:0]   POS_ERR,
  output logic signed [sdj_pkg::CMD_W-1:0] SPEED_CMD,
  output logic                           FAST_STOP,
  output logic                           DIRECT_ACTIVE
);
  import sdj_pkg::*;

  localparam logic signed [ACC_W-1:0] SAT_HI = ACC_W'(FULL_CMD);
  localparam logic signed [ACC_W-1:0] SAT_LO = -ACC_W'(FULL_CMD);
  localparam logic [ACC_W-1:0] RPM_SCALE =
    ACC_W'((64'(FULL_CMD) << 16) / 64'(FULL_RPM));

  function automatic logic signed [CMD_W-1:0] sat_cmd(
    input logic signed [ACC_W-1:0] v);
    if (v > SAT_HI) begin
      sat_cmd = CMD_W'(FULL_CMD);
    end else if (v < SAT_LO) begin
      sat_cmd = -CMD_W'(FULL_CMD);
    end else begin
      sat_cmd = v[CMD_W-1:0];
    end
  endfunction : sat_cmd

  // Registers.
  logic [3:0]              mode_reg;
  logic signed [CMD_W-1:0] direct_reg;
  logic [SET_W-1:0]        ramp_reg;
  logic [SET_W-1:0]        jogsp_reg;
  logic [SET_W-1:0]        kp_reg;
  logic [SET_W-1:0]        ki_reg;
  logic [2:0]              pin_meta_reg;
  logic [2:0]              pin_sync_reg;
  logic                    run_prev_reg;
  sdj_state_t              state_reg;
  sdj_state_t              state_next;
  logic [SET_W-1:0]        rpm_reg;
  logic [SET_W-1:0]        rpm_next;
  logic signed [CMD_W-1:0] integ_reg;
  logic signed [CMD_W-1:0] integ_next;
  logic signed [CMD_W-1:0] speed_next;

  logic                    run_lvl;
  logic                    stop_lvl;
  logic                    jog_lvl;
  logic                    run_rise;
  logic                    direct_mode;
  logic                    wr_en;
  logic                    setup;
  logic                    step;
  logic                    ramp_en;
  logic [SET_W-1:0]        dda_rate;
  logic signed [CMD_W-1:0] wr_direct;
  logic signed [ACC_W-1:0] wdata_s;
  logic signed [ACC_W-1:0] p_full;
  logic signed [ACC_W-1:0] i_full;
  logic signed [ACC_W-1:0] pi_sum;
  logic signed [CMD_W-1:0] pi_out;
  logic signed [CMD_W-1:0] jog_cmd;
  logic [ACC_W-1:0]        jog_prod;
  logic [31:0]             rd_data;
  logic                    rd_err;

  assign run_lvl  = pin_sync_reg[2];
  assign stop_lvl = pin_sync_reg[1];
  assign jog_lvl  = pin_sync_reg[0];
  assign run_rise = run_lvl && !run_prev_reg;

  assign direct_mode = (mode_reg == MODE_DIRECT);
  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign wr_en = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready
                 && APB_REQ.pwrite;

  // Pins pass two flip-flops; only the second stage is read.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      run_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {RUN_PIN, STOP_PIN, JOG_PIN};
      pin_sync_reg <= pin_meta_reg;
      run_prev_reg <= run_lvl;
    end
  end

  // Direct writes are taken as signed 16-bit; values outside +/-4095 are clamped to the converter range.
  assign wdata_s   = ACC_W'($signed(APB_REQ.pwdata[15:0]));
  assign wr_direct = sat_cmd(wdata_s);

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mode_reg   <= MODE_RST;
      direct_reg <= DIRECT_RST;
      ramp_reg   <= RAMP_RST;
      jogsp_reg  <= JOGSP_RST;
      kp_reg     <= KP_RST;
      ki_reg     <= KI_RST;
    end else if (wr_en) begin
      case (APB_REQ.paddr)
        OFS_MODE:   mode_reg   <= APB_REQ.pwdata[3:0];
        OFS_DIRECT: direct_reg <= wr_direct;
        OFS_RAMP:   ramp_reg   <= APB_REQ.pwdata[SET_W-1:0];
        OFS_JOGSP:  jogsp_reg  <= APB_REQ.pwdata[SET_W-1:0];
        OFS_KP:     kp_reg     <= APB_REQ.pwdata[SET_W-1:0];
        OFS_KI:     ki_reg     <= APB_REQ.pwdata[SET_W-1:0];
        default:    mode_reg   <= mode_reg;
      endcase
    end
  end

  // Stop always wins; jog is taken only from fast stop.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_FSTOP: begin
        if (!stop_lvl && jog_lvl) begin
          state_next = ST_JOG;
        end else if (!stop_lvl && run_rise) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_lvl) begin
          state_next = ST_FSTOP;
        end
      end
      ST_JOG: begin
        if (stop_lvl) begin
          state_next = ST_FSTOP;
        end else if (!jog_lvl) begin
          state_next = ST_JOG_DOWN;
        end
      end
      ST_JOG_DOWN: begin
        if (stop_lvl || rpm_reg == '0) begin
          state_next = ST_FSTOP;
        end
      end
      default: state_next = ST_FSTOP;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_reg <= ST_FSTOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // A zero setpoint would stall the down ramp, so the rate floor is one.
  assign ramp_en  = (state_reg == ST_JOG) || (state_reg == ST_JOG_DOWN);
  assign dda_rate = (jogsp_reg == '0) ? SET_W'(1) : jogsp_reg;

  sdj_ramp_dda #(
    .UNIT_CYC (UNIT_CYC)
  ) u_ramp (
    .clock  (CLOCK),
    .srst   (SRST),
    .enable (ramp_en),
    .rate   (dda_rate),
    .period (ramp_reg),
    .step   (step)
  );

  always_comb begin
    rpm_next = rpm_reg;
    case (state_reg)
      ST_JOG: begin
        if (step && rpm_reg < jogsp_reg) begin
          rpm_next = rpm_reg + SET_W'(1);
        end else if (step && rpm_reg > jogsp_reg) begin
          rpm_next = rpm_reg - SET_W'(1);
        end
      end
      ST_JOG_DOWN: begin
        if (step && rpm_reg != '0) begin
          rpm_next = rpm_reg - SET_W'(1);
        end
      end
      default: rpm_next = '0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rpm_reg <= '0;
    end else begin
      rpm_reg <= rpm_next;
    end
  end

  assign jog_prod = ACC_W'(rpm_reg) * RPM_SCALE;
  assign jog_cmd  = sat_cmd($signed(jog_prod >> 16));

  // The integrator is held clear outside closed-loop run so that no
  // windup is carried into the next run.
  assign p_full = ACC_W'($signed({1'b0, kp_reg})) * ACC_W'(POS_ERR);
  assign i_full = ACC_W'($signed({1'b0, ki_reg})) * ACC_W'(POS_ERR);
  assign integ_next = sat_cmd(ACC_W'(integ_reg) + (i_full >>> KI_SHIFT));
  assign pi_sum = (p_full >>> KP_SHIFT) + ACC_W'(integ_reg);
  assign pi_out = sat_cmd(pi_sum);

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      integ_reg <= '0;
    end else if (state_reg == ST_RUN && !direct_mode) begin
      integ_reg <= integ_next;
    end else begin
      integ_reg <= '0;
    end
  end

  always_comb begin
    case (state_reg)
      ST_RUN:      speed_next = direct_mode ? direct_reg : pi_out;
      ST_JOG:      speed_next = jog_cmd;
      ST_JOG_DOWN: speed_next = jog_cmd;
      default:     speed_next = '0;
    endcase
  end

  // The direct value passes unchanged: linear in sign and magnitude.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      SPEED_CMD     <= '0;
      FAST_STOP     <= 1'b1;
      DIRECT_ACTIVE <= 1'b0;
    end else begin
      SPEED_CMD     <= speed_next;
      FAST_STOP     <= (state_next == ST_FSTOP);
      DIRECT_ACTIVE <= direct_mode;
    end
  end

  always_comb begin
    rd_err = 1'b0;
    case (APB_REQ.paddr)
      OFS_MODE:   rd_data = 32'(mode_reg);
      OFS_DIRECT: rd_data = 32'($signed(direct_reg));
      OFS_RAMP:   rd_data = 32'(ramp_reg);
      OFS_JOGSP:  rd_data = 32'(jogsp_reg);
      OFS_KP:     rd_data = 32'(kp_reg);
      OFS_KI:     rd_data = 32'(ki_reg);
      OFS_STATUS: rd_data = {27'h0, direct_mode, state_reg};
      OFS_SPEED:  rd_data = {rpm_reg, 3'h0, SPEED_CMD};
      default: begin
        rd_data = 32'h0;
        rd_err  = 1'b1;
      end
    endcase
  end

  // The response is registered in the setup cycle, so access has no wait state and every bus output is on a flip-flop.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      APB_RSP <= '0;
    end else if (setup) begin
      APB_RSP.pready  <= 1'b1;
      APB_RSP.pslverr <= rd_err;
      APB_RSP.prdata  <= APB_REQ.pwrite ? 32'h0 : rd_data;
    end else begin
      APB_RSP <= '0;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  a_direct_bypass: assert property (
    state_reg == ST_RUN && direct_mode |=> SPEED_CMD == $past(direct_reg))
    else $error("direct run command differs from direct value");

  // FAST_STOP follows the next state, so it falls together with a jog or run start.
  a_stop_zero: assert property (
    state_reg == ST_FSTOP |=> SPEED_CMD == '0 && FAST_STOP == (state_reg == ST_FSTOP))
    else $error("command not zero in fast stop");

  a_mode_decode: assert property (
    mode_reg == 4'h2 |=> DIRECT_ACTIVE)
    else $error("mode 2 did not raise direct flag");

  a_jog_entry: assert property (
    state_reg == ST_JOG && $past(state_reg) != ST_JOG |->
      $past(state_reg) == ST_FSTOP)
    else $error("jog entered from outside fast stop");

  a_jog_step: assert property (
    state_reg == ST_JOG && !step |=> rpm_reg == $past(rpm_reg))
    else $error("jog speed moved without a ramp step");

  a_jog_down_end: assert property (
    state_reg == ST_JOG_DOWN && rpm_reg == '0 |=> state_reg == ST_FSTOP)
    else $error("down ramp at zero did not reach fast stop");

  a_reset_values: assert property (
    $past(SRST) |-> direct_reg == '0 && jogsp_reg == 16'h0032
      && kp_reg == 16'h0bb8 && ki_reg == 16'h0001)
    else $error("settings wrong after reset");

  a_integ_clear: assert property (
    direct_mode |=> integ_reg == '0)
    else $error("integrator active in direct mode");

  a_cmd_range: assert property (
    SPEED_CMD <= 13'sh0fff && SPEED_CMD >= -13'sh0fff)
    else $error("speed command beyond converter range");

endmodule : sdj_core

// ===== rtl/sdj_ramp_dda.sv
// Purpose: Rate generator giving one-cycle step pulses for the jog ramp.
// Assumes: Step rate is rate / (period * unit_cyc) steps per cycle.
// Notes:   A zero period steps on every enabled cycle.
`timescale 1ns/1ps
module sdj_ramp_dda #(
  parameter int unsigned UNIT_CYC = sdj_pkg::RAMP_UNIT_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic                     enable,
  input  wire logic [sdj_pkg::SET_W-1:0] rate,
  input  wire logic [sdj_pkg::SET_W-1:0] period,
  output logic                          step
);
  import sdj_pkg::*;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] threshold;

  // Bresenham style accumulation avoids a divider for the ramp slope.
  assign threshold = ACC_W'(period) * ACC_W'(UNIT_CYC);
  assign acc_sum   = acc_reg + ACC_W'(rate);

  always_ff @(posedge clock) begin
    if (srst || !enable) begin
      acc_reg <= '0;
      step    <= 1'b0;
    end else if (acc_sum >= threshold) begin
      acc_reg <= acc_sum - threshold;
      step    <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      step    <= 1'b0;
    end
  end

endmodule : sdj_ramp_dda

// ===== shared/sdj_pkg.sv
// Purpose: Shared constants and types for the speed command block.
// Assumes: 100 MHz CLOCK, APB with 32-bit data and byte addresses.
// Notes:   Ramp time is held in tenths of a second.
package sdj_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_UNIT_NS  = 100_000_000;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int CMD_W  = 13;
  localparam int SET_W  = 16;
  localparam int ACC_W  = 48;

  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIRECT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RAMP   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_JOGSP  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_KP     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_KI     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SPEED  = 8'h1c;

  localparam int                FULL_CMD    = 4095;
  localparam logic [3:0]        MODE_DIRECT = 4'h2;
  localparam logic [3:0]        MODE_RST    = 4'h1;
  localparam logic [CMD_W-1:0]  DIRECT_RST  = 13'h0000;
  localparam logic [SET_W-1:0]  RAMP_RST    = 16'h0032;
  localparam logic [SET_W-1:0]  JOGSP_RST   = 16'h0032;
  localparam logic [SET_W-1:0]  KP_RST      = 16'h0bb8;
  localparam logic [SET_W-1:0]  KI_RST      = 16'h0001;

  typedef enum logic [3:0] {
    ST_FSTOP    = 4'b0001,
    ST_RUN      = 4'b0010,
    ST_JOG      = 4'b0100,
    ST_JOG_DOWN = 4'b1000
  } sdj_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } sdj_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sdj_apb_rsp_t;

endpackage : sdj_pkg

// ===== sim/sdj_drive_model.sv
// Purpose: Motor drive stand-in fed by the analog speed command.
// Assumes: Command is two's complement counts, +/-4095 full scale.
// Notes:   Splits the command into magnitude and direction, one cycle late.
`timescale 1ns/1ps
module sdj_drive_model (
  input  wire logic                             clock,
  input  wire logic                             srst,
  input  wire logic signed [sdj_pkg::CMD_W-1:0] speed_cmd,
  output logic [11:0]                           drive_mag,
  output logic                                  drive_rev
);
  import sdj_pkg::*;

  // The drive sees only sign and magnitude, so a wrong sign shows as reverse.
  always_ff @(posedge clock) begin
    if (srst) begin
      drive_mag <= 12'h000;
      drive_rev <= 1'b0;
    end else begin
      drive_rev <= speed_cmd[CMD_W-1];
      drive_mag <= 12'(speed_cmd[CMD_W-1] ? -speed_cmd : speed_cmd);
    end
  end
endmodule : sdj_drive_model

// ===== sim/tb_speed_command_direct_jog.sv
// Purpose: Self-checking bench for the speed command block.
// Assumes: UNIT_CYC is cut to 10 cycles so ramps stay short.
// Notes:   Read results are noted in a queue and checked by a watcher.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module tb_speed_command_direct_jog;
  import sdj_pkg::*;
  logic                    CLOCK = 1'b0;
  logic                    SRST  = 1'b1;
  sdj_apb_req_t            req   = '0;
  sdj_apb_rsp_t            rsp;
  logic                    run   = 1'b0;
  logic                    stp   = 1'b0;
  logic                    jog   = 1'b0;
  logic signed [15:0]      err   = 16'sh012c;
  logic signed [CMD_W-1:0] cmd;
  logic                    fstop;
  logic                    dact;
  logic [11:0]             mag;
  logic                    rev;
  int                      mismatches  = 0;
  int                      comparisons = 0;
  logic [32:0]             expq[$];
  logic [32:0]             exp_head;
  localparam logic [2:0]   P_RUN = 3'b100;
  localparam logic [2:0]   P_STP = 3'b010;
  localparam logic [2:0]   P_JOG = 3'b001;
  int                      vals[5];
  int                      n;
  int                      v;
  int                      je;

  always #5 CLOCK = ~CLOCK;

  sdj_core #(.UNIT_CYC(10)) sdj_core_inst (.CLOCK(CLOCK), .SRST(SRST), .APB_REQ(req),
    .APB_RSP(rsp), .RUN_PIN(run), .STOP_PIN(stp), .JOG_PIN(jog), .POS_ERR(err),
    .SPEED_CMD(cmd), .FAST_STOP(fstop), .DIRECT_ACTIVE(dact));
  sdj_drive_model sdj_drive_model_inst (.clock(CLOCK), .srst(SRST), .speed_cmd(cmd),
    .drive_mag(mag), .drive_rev(rev));

  always @(posedge CLOCK) begin
    if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
      // Popped once here because the compare macro reads its operands twice.
      exp_head = expq.pop_front();
      `CHK({rsp.pslverr, rsp.prdata}, exp_head)
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // One idle cycle ends every transfer so req is never assigned twice at one edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp = '0);
    if (!wr) expq.push_back(exp);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge CLOCK);
    req.penable <= 1'b1;
    // Only the watchdog may end this wait; a hung slave fails the run there.
    do begin
      @(posedge CLOCK);
    end while (!rsp.pready);
    req <= '0;
    @(posedge CLOCK);
  endtask : apb

  task automatic tick(input int c);
    repeat (c) @(posedge CLOCK);
  endtask : tick

  // The mask picks run, stop or jog; six cycles outlast the two-stage synchroniser.
  task automatic pulse(input logic [2:0] m);
    {run, stp, jog} <= {run, stp, jog} | m;
    tick(6);
    {run, stp, jog} <= {run, stp, jog} & ~m;
    tick(2);
  endtask : pulse

  initial begin
    #100_000;
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(52));
    vals = '{4095, 2048, 0, 0, -4095};
    vals[3] = $urandom_range(8190) - 4095;
    tick(10);
    SRST <= 1'b0;
    tick(1);
    `CHK({fstop, dact, cmd}, {1'b1, 1'b0, 13'h0000})
    apb(0, OFS_MODE, 0, 33'h001);
    apb(0, OFS_DIRECT, 0, 33'h000);
    apb(0, OFS_RAMP, 0, 33'h032);
    apb(0, OFS_JOGSP, 0, 33'h032);
    apb(0, OFS_KP, 0, 33'hbb8);
    apb(0, OFS_KI, 0, 33'h001);
    apb(0, 8'h20, 0, 33'h100000000);
    apb(1, OFS_MODE, 32'h2);
    tick(1);
    `CHK(dact, 1'b1)
    apb(1, OFS_DIRECT, 32'h1388);
    apb(0, OFS_DIRECT, 0, 33'hfff);
    `CHK(cmd, 13'h0000)
    pulse(P_RUN);
    apb(0, OFS_STATUS, 0, 33'h012);
    pulse(P_JOG);
    apb(0, OFS_STATUS, 0, 33'h012);
    foreach (vals[i]) begin
      apb(1, OFS_DIRECT, 32'(vals[i]));
      tick(2);
      `CHK(cmd, 13'(vals[i]))
      `CHK({rev, mag}, {vals[i] < 0, 12'(vals[i] < 0 ? -vals[i] : vals[i])})
    end
    pulse(P_STP);
    `CHK({fstop, cmd}, {1'b1, 13'h0000})
    apb(1, OFS_MODE, 32'h1);
    apb(1, OFS_KI, 32'h0);
    apb(1, OFS_KP, 32'h1000);
    v = $urandom_range(2000) - 1000;
    err <= 16'(v);
    pulse(P_RUN);
    `CHK(cmd, 13'(v))
    apb(1, OFS_KP, 32'h2000);
    tick(2);
    `CHK(cmd, 13'(2 * v))
    // With a fixed error the integral term must climb by one count per cycle.
    err <= 16'sh0002;
    apb(1, OFS_KI, 32'h8000);
    tick(2);
    n = cmd;
    tick(1);
    `CHK(int'(cmd) - n, 1)
    pulse(P_STP);
    apb(1, OFS_RAMP, 32'h2);
    apb(1, OFS_JOGSP, 32'h5);
    je = (5 * ((FULL_CMD * 65536) / 3000)) >>> 16;
    jog <= 1'b1;
    n = 0;
    while (fstop !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    `CHK(fstop, 1'b0)
    n = 0;
    while (cmd !== 13'(je) && n < 100) begin
      tick(1);
      n++;
    end
    `CHK(n >= 16 && n <= 24, 1'b1)
    tick(10);
    `CHK(cmd, 13'(je))
    jog <= 1'b0;
    tick(6);
    `CHK(fstop, 1'b0)
    n = 0;
    while (fstop !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    tick(1);
    `CHK({fstop, cmd, n >= 10}, {1'b1, 13'h0000, 1'b1})
    close_out();
  end
endmodule : tb_speed_command_direct_jog
